/* logic/mscp_map.svh */
// Register indices, field positions, reset values and timing counts
// Assumes a 10 MHz pclk; byte address of a register is four times its index
`ifndef MSCP_MAP_SVH
`define MSCP_MAP_SVH

`define MSCP_CLK_MHZ       10
`define MSCP_NUM_CFG       12
`define MSCP_IX_CTRL       4'h0
`define MSCP_IX_STOPMIN    4'h1
`define MSCP_IX_ANA_LVL    4'h2
`define MSCP_IX_ANA_FS     4'h3
`define MSCP_IX_PWM_LVL    4'h4
`define MSCP_IX_FRQ_LVL    4'h5
`define MSCP_IX_FRQ_FS     4'h6
`define MSCP_IX_PWM_HOST   4'h7
`define MSCP_IX_HOST_SPD   4'h8
`define MSCP_IX_SLEEP_DLY  4'h9
`define MSCP_IX_FULL_SCALE 4'ha
`define MSCP_IX_RAMP       4'hb
`define MSCP_IX_STAT       4'hc
`define MSCP_IX_REFS       4'hd
`define MSCP_IX_REF2       4'he
`define MSCP_IX_MEAS       4'hf

`define MSCP_CTRL_SRC      0
`define MSCP_CTRL_LOOP     2
`define MSCP_CTRL_RANGE    4
`define MSCP_LO            0
`define MSCP_HI            16
`define MSCP_RAMP_DEC      8

`define MSCP_RST_CTRL      32'h0000_0000
`define MSCP_RST_STOPMIN   32'h0033_0020
`define MSCP_RST_ANA_LVL   32'h00c0_00a0
`define MSCP_RST_ANA_FS    32'h004d_0e00
`define MSCP_RST_PWM_LVL   32'h0014_000a
`define MSCP_RST_FRQ_LVL   32'h0004_0002
`define MSCP_RST_FRQ_FS    32'h0100_0400
`define MSCP_RST_PWM_HOST  32'h0010_0105
`define MSCP_RST_HOST_SPD  32'h0000_0000
`define MSCP_RST_SLEEP_DLY 32'h0000_2710
`define MSCP_RST_FULL      32'h0064_0bb8
`define MSCP_RST_RAMP      32'h0000_0204

`define MSCP_CMD_FULL      10'h3ff
`define MSCP_PWM_LAST      10'h3fe
`define MSCP_FREQ_GATE_US  100000
`define MSCP_FREQ_GATE_CYC (`MSCP_FREQ_GATE_US * `MSCP_CLK_MHZ)
`define MSCP_RAMP_TICK_US  10
`define MSCP_RAMP_TICK_CYC (`MSCP_RAMP_TICK_US * `MSCP_CLK_MHZ)

`endif

/* logic/mscp_pkg.sv */
// Types shared by the speed command path
// Assumes constants come from mscp_map.svh
`default_nettype none
package mscp_pkg;
  typedef enum logic [1:0] {
    SRC_ANALOG = 2'h0,
    SRC_PWM    = 2'h1,
    SRC_HOST   = 2'h2,
    SRC_FREQ   = 2'h3
  } mscp_src_e;
  typedef enum logic [1:0] {
    LOOP_OPEN  = 2'h0,
    LOOP_SPEED = 2'h1,
    LOOP_POWER = 2'h2,
    LOOP_RSVD  = 2'h3
  } mscp_loop_e;
endpackage : mscp_pkg
`default_nettype wire

/* logic/mscp_meas_if.sv */
// Speed pin measurement results passed from the pin meter to the core
// Assumes both ends run on pclk
`timescale 1ns/1ns
`default_nettype none
interface mscp_meas_if;
  logic        pin_lvl;
  logic [9:0]  duty;
  logic [15:0] freq;
  logic [1:0]  range;
  modport meas (output pin_lvl, output duty, output freq, input range);
  modport core (input pin_lvl, input duty, input freq, output range);
endinterface : mscp_meas_if
`default_nettype wire

/* logic/mscp_pin_meas.sv */
// Speed pin synchroniser, duty meter and frequency counter
// Assumes the speed pin is asynchronous to pclk
`include "mscp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module mscp_pin_meas
  import mscp_pkg::*;
#(
  parameter int GATE_CYC = `MSCP_FREQ_GATE_CYC
) (
  // Clock and reset
  input wire logic  pclk,
  input wire logic  presetn,
  // Asynchronous speed pin
  input wire logic  speed_pin,
  // Measurement results
  mscp_meas_if.meas mif
);
  logic [2:0]  sync_q, sync_d;
  logic        lvl_q, lvl_d, tick_w;
  logic [5:0]  presc_q, presc_d, lim_w;
  logic [9:0]  smp_q, smp_d, high_q, high_d, duty_q, duty_d;
  logic [31:0] gate_q, gate_d;
  logic [15:0] edge_q, edge_d, freq_q, freq_d;

  always_comb begin
    sync_d = {sync_q[1:0], speed_pin};
    lvl_d  = (sync_q[1] == sync_q[2]) ? sync_q[2] : lvl_q;
    // Slower sampling widens the window for low input PWM rates
    unique case (mif.range)
      2'h0: lim_w = 6'h00;
      2'h1: lim_w = 6'h03;
      2'h2: lim_w = 6'h0f;
      2'h3: lim_w = 6'h3f;
    endcase
    tick_w  = (presc_q >= lim_w);
    presc_d = tick_w ? 6'h00 : presc_q + 6'h01;
    smp_d   = smp_q;
    high_d  = high_q;
    duty_d  = duty_q;
    if (tick_w && smp_q == `MSCP_PWM_LAST) begin
      duty_d = high_q + {9'h000, lvl_q};
      high_d = 10'h000;
      smp_d  = 10'h000;
    end else if (tick_w) begin
      high_d = high_q + {9'h000, lvl_q};
      smp_d  = smp_q + 10'h001;
    end
    gate_d = gate_q + 32'h0000_0001;
    edge_d = edge_q;
    freq_d = freq_q;
    if (lvl_d && !lvl_q && edge_q != 16'hffff) begin
      edge_d = edge_q + 16'h0001;
    end
    if (gate_q >= 32'(GATE_CYC - 1)) begin
      gate_d = 32'h0000_0000;
      freq_d = edge_d;
      edge_d = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_q  <= 3'h0;
      lvl_q   <= 1'b0;
      presc_q <= 6'h00;
      smp_q   <= 10'h000;
      high_q  <= 10'h000;
      duty_q  <= 10'h000;
      gate_q  <= 32'h0000_0000;
      edge_q  <= 16'h0000;
      freq_q  <= 16'h0000;
    end else begin
      sync_q  <= sync_d;
      lvl_q   <= lvl_d;
      presc_q <= presc_d;
      smp_q   <= smp_d;
      high_q  <= high_d;
      duty_q  <= duty_d;
      gate_q  <= gate_d;
      edge_q  <= edge_d;
      freq_q  <= freq_d;
    end
  end

  assign mif.pin_lvl = lvl_q;
  assign mif.duty    = duty_q;
  assign mif.freq    = freq_q;
endmodule : mscp_pin_meas
`default_nettype wire

/* logic/mscp_ramp.sv */
// Slew limiter that walks the applied duty toward its target
// Assumes target and limits are registered on pclk
`include "mscp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module mscp_ramp #(
  parameter int W        = 10,
  parameter int TICK_CYC = `MSCP_RAMP_TICK_CYC
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Target and step limits per tick, zero means jump
  input  wire logic [W-1:0] target,
  input  wire logic [7:0]   accel,
  input  wire logic [7:0]   decel,
  // Applied duty
  output logic [W-1:0]      applied
);
  logic [15:0]  tick_q, tick_d;
  logic [W-1:0] duty_q, duty_d, diff_w;
  logic         tick_w;

  always_comb begin
    tick_w = (tick_q >= 16'(TICK_CYC - 1));
    tick_d = tick_w ? 16'h0000 : tick_q + 16'h0001;
    diff_w = (target > duty_q) ? target - duty_q : duty_q - target;
    duty_d = duty_q;
    // Slow decel keeps regenerated energy off the supply rail
    if (tick_w && target > duty_q) begin
      duty_d = (accel == 8'h00 || diff_w <= W'(accel)) ? target : duty_q + W'(accel);
    end else if (tick_w && target < duty_q) begin
      duty_d = (decel == 8'h00 || diff_w <= W'(decel)) ? target : duty_q - W'(decel);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_q <= 16'h0000;
      duty_q <= '0;
    end else begin
      tick_q <= tick_d;
      duty_q <= duty_d;
    end
  end

  assign applied = duty_q;

  property p_ramp_rise;
    @(posedge pclk) disable iff (!presetn)
    tick_w && target > duty_q |=> duty_q > $past(duty_q) && duty_q <= $past(target);
  endproperty
  a_ramp_rise: assert property (p_ramp_rise)
    else $error("applied duty did not rise toward target");

  property p_ramp_settle;
    @(posedge pclk) disable iff (!presetn)
    $stable(target) && duty_q == target |=> duty_q == $past(target);
  endproperty
  a_ramp_settle: assert property (p_ramp_settle)
    else $error("applied duty left a steady target");
endmodule : mscp_ramp
`default_nettype wire

/* logic/mscp_top.sv */
// Speed command path: APB registers, source selection and conversion,
// standby and sleep, loop reference mapping and the applied output duty.
// Assumes APB and the ADC code are on pclk; the speed pin is asynchronous.
`include "mscp_map.svh"
`timescale 1ns/1ns
`default_nettype none

module mscp_top
  import mscp_pkg::*;
#(
  parameter int FREQ_GATE_CYC = `MSCP_FREQ_GATE_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Speed inputs
  input  wire logic        speed_pin,
  input  wire logic [11:0] adc_code,
  // Command path results
  output logic [9:0]       duty_command,
  output logic [9:0]       target_output_duty,
  output logic [15:0]      speed_reference,
  output logic [15:0]      power_reference,
  output logic [9:0]       applied_output_duty,
  output logic             standby,
  output logic             sleep_mode,
  output logic             motor_stopped
);
  localparam logic [31:0] CFG_RST [`MSCP_NUM_CFG] = '{
    `MSCP_RST_CTRL, `MSCP_RST_STOPMIN, `MSCP_RST_ANA_LVL, `MSCP_RST_ANA_FS,
    `MSCP_RST_PWM_LVL, `MSCP_RST_FRQ_LVL, `MSCP_RST_FRQ_FS, `MSCP_RST_PWM_HOST,
    `MSCP_RST_HOST_SPD, `MSCP_RST_SLEEP_DLY, `MSCP_RST_FULL, `MSCP_RST_RAMP};

  mscp_meas_if mif ();

  logic [31:0] cfg_q [`MSCP_NUM_CFG];
  logic [31:0] cfg_d [`MSCP_NUM_CFG];
  logic [31:0] prdata_q, prdata_d, rd_w;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;
  logic [3:0]  idx_w;
  logic        setup_w, err_w, wr_w;
  mscp_src_e   src_w;
  mscp_loop_e  loop_w;
  logic [9:0]  stop_w, min_w, pwm_ent_w, pwm_exit_w, host_sb_w, host_w;
  logic [11:0] ana_ent_w, ana_exit_w, ana_fs_w;
  logic [15:0] ana_slope_w, pwm_slope_w, frq_ent_w, frq_exit_w, frq_fs_w;
  logic [15:0] frq_slope_w, fs_spd_w, fs_pwr_w, x_w;
  logic [23:0] dly_w, zcnt_q, zcnt_d;
  logic [7:0]  acc_w, dec_w;
  logic        sb_q, sb_d, sleep_q, sleep_d, stop_q, stop_d;
  logic [9:0]  cmd_q, cmd_d, tgt_q, tgt_d, ramp_q, ramp_d, eff_w, applied_w;
  logic [15:0] spd_q, spd_d, pwr_q, pwr_d;

  function automatic logic [9:0] lin_map(input logic [15:0] x, input logic [15:0] ex,
                                         input logic [15:0] fs, input logic [15:0] slope);
    logic [31:0] p;
    p = ({16'h0000, x - ex} * {16'h0000, slope}) >> 8;
    if (x >= fs) begin
      lin_map = `MSCP_CMD_FULL;
    end else if (x < ex) begin
      lin_map = 10'h000;
    end else begin
      lin_map = (p > {22'h00_0000, `MSCP_CMD_FULL}) ? `MSCP_CMD_FULL : p[9:0];
    end
  endfunction : lin_map

  // Full command maps exactly onto full scale, not one step short
  function automatic logic [15:0] mul_ref(input logic [9:0] eff, input logic [15:0] fs);
    logic [31:0] p;
    p = {22'h00_0000, eff} * {16'h0000, fs};
    mul_ref = (eff == `MSCP_CMD_FULL) ? fs : p[25:10];
  endfunction : mul_ref

  assign src_w       = mscp_src_e'(cfg_q[`MSCP_IX_CTRL][`MSCP_CTRL_SRC +: 2]);
  assign loop_w      = mscp_loop_e'(cfg_q[`MSCP_IX_CTRL][`MSCP_CTRL_LOOP +: 2]);
  assign mif.range   = cfg_q[`MSCP_IX_CTRL][`MSCP_CTRL_RANGE +: 2];
  assign stop_w      = cfg_q[`MSCP_IX_STOPMIN][`MSCP_LO +: 10];
  assign min_w       = cfg_q[`MSCP_IX_STOPMIN][`MSCP_HI +: 10];
  assign ana_ent_w   = cfg_q[`MSCP_IX_ANA_LVL][`MSCP_LO +: 12];
  assign ana_exit_w  = cfg_q[`MSCP_IX_ANA_LVL][`MSCP_HI +: 12];
  assign ana_fs_w    = cfg_q[`MSCP_IX_ANA_FS][`MSCP_LO +: 12];
  assign ana_slope_w = cfg_q[`MSCP_IX_ANA_FS][`MSCP_HI +: 16];
  assign pwm_ent_w   = cfg_q[`MSCP_IX_PWM_LVL][`MSCP_LO +: 10];
  assign pwm_exit_w  = cfg_q[`MSCP_IX_PWM_LVL][`MSCP_HI +: 10];
  assign frq_ent_w   = cfg_q[`MSCP_IX_FRQ_LVL][`MSCP_LO +: 16];
  assign frq_exit_w  = cfg_q[`MSCP_IX_FRQ_LVL][`MSCP_HI +: 16];
  assign frq_fs_w    = cfg_q[`MSCP_IX_FRQ_FS][`MSCP_LO +: 16];
  assign frq_slope_w = cfg_q[`MSCP_IX_FRQ_FS][`MSCP_HI +: 16];
  assign pwm_slope_w = cfg_q[`MSCP_IX_PWM_HOST][`MSCP_LO +: 16];
  assign host_sb_w   = cfg_q[`MSCP_IX_PWM_HOST][`MSCP_HI +: 10];
  assign host_w      = cfg_q[`MSCP_IX_HOST_SPD][`MSCP_LO +: 10];
  assign dly_w       = cfg_q[`MSCP_IX_SLEEP_DLY][`MSCP_LO +: 24];
  assign fs_spd_w    = cfg_q[`MSCP_IX_FULL_SCALE][`MSCP_LO +: 16];
  assign fs_pwr_w    = cfg_q[`MSCP_IX_FULL_SCALE][`MSCP_HI +: 16];
  assign acc_w       = cfg_q[`MSCP_IX_RAMP][`MSCP_LO +: 8];
  assign dec_w       = cfg_q[`MSCP_IX_RAMP][`MSCP_RAMP_DEC +: 8];

  // No wait state; read data and the answer are registered in the setup cycle so they come from flops
  always_comb begin
    idx_w   = paddr[5:2];
    setup_w = psel & ~penable;
    err_w   = (paddr[7:6] != 2'h0) | (paddr[1:0] != 2'h0) |
              (pwrite & (idx_w >= `MSCP_IX_STAT));
    unique case (idx_w)
      `MSCP_IX_STAT: rd_w = {16'h0000, 3'h0, stop_q, sleep_q, sb_q, cmd_q};
      `MSCP_IX_REFS: rd_w = {6'h00, applied_w, 6'h00, tgt_q};
      `MSCP_IX_REF2: rd_w = {pwr_q, spd_q};
      `MSCP_IX_MEAS: rd_w = {mif.freq, 6'h00, mif.duty};
      default:       rd_w = cfg_q[idx_w];
    endcase
    prdata_d  = setup_w ? (err_w ? 32'h0000_0000 : rd_w) : prdata_q;
    pready_d  = setup_w;
    pslverr_d = setup_w & err_w;
    wr_w      = psel & penable & pready_q & pwrite & ~pslverr_q;
    cfg_d     = cfg_q;
    if (wr_w) begin
      cfg_d[idx_w] = pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      cfg_q     <= CFG_RST;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      cfg_q     <= cfg_d;
    end
  end

  // Source selection; sb_q gives hysteresis between entry and exit levels for the analog, PWM and frequency sources
  always_comb begin
    sb_d    = sb_q;
    sleep_d = 1'b0;
    zcnt_d  = 24'h00_0000;
    cmd_d   = 10'h000;
    x_w     = 16'h0000;
    unique case (src_w)
      SRC_ANALOG: begin
        x_w = {4'h0, adc_code};
        if (adc_code <= ana_ent_w) begin
          sb_d = 1'b1;
        end else if (adc_code >= ana_exit_w) begin
          sb_d = 1'b0;
        end
        cmd_d = sb_d ? 10'h000 : lin_map(x_w, {4'h0, ana_exit_w}, {4'h0, ana_fs_w},
                                         ana_slope_w);
      end
      SRC_PWM: begin
        x_w = {6'h00, mif.duty};
        if (mif.duty <= pwm_ent_w) begin
          sb_d = 1'b1;
        end else if (mif.duty >= pwm_exit_w) begin
          sb_d = 1'b0;
        end
        cmd_d = sb_d ? 10'h000 : lin_map(x_w, {6'h00, pwm_exit_w},
                                         {6'h00, `MSCP_CMD_FULL}, pwm_slope_w);
      end
      SRC_HOST: begin
        zcnt_d = (host_w != 10'h000) ? 24'h00_0000 :
                 (zcnt_q == 24'hff_ffff) ? zcnt_q : zcnt_q + 24'h00_0001;
        sleep_d = sleep_q;
        if (sleep_q && mif.pin_lvl) begin
          sleep_d = 1'b0;
        end else if (!mif.pin_lvl && host_w == 10'h000 && zcnt_q > dly_w) begin
          sleep_d = 1'b1;
        end
        sb_d  = (host_w <= host_sb_w) && mif.pin_lvl;
        cmd_d = (sleep_d || sb_d) ? 10'h000 : host_w;
      end
      SRC_FREQ: begin
        x_w = mif.freq;
        if (mif.freq <= frq_ent_w) begin
          sb_d = 1'b1;
        end else if (mif.freq >= frq_exit_w) begin
          sb_d = 1'b0;
        end
        cmd_d = sb_d ? 10'h000 : lin_map(x_w, frq_exit_w, frq_fs_w, frq_slope_w);
      end
    endcase
  end

  // Reference mapping from the registered command
  always_comb begin
    stop_d = (cmd_q < stop_w);
    eff_w  = (cmd_q < min_w) ? min_w : cmd_q;
    tgt_d  = 10'h000;
    spd_d  = 16'h0000;
    pwr_d  = 16'h0000;
    ramp_d = stop_d ? 10'h000 : eff_w;
    if (!stop_d) begin
      unique case (loop_w)
        LOOP_OPEN:  tgt_d = eff_w;
        LOOP_SPEED: spd_d = mul_ref(eff_w, fs_spd_w);
        LOOP_POWER: pwr_d = mul_ref(eff_w, fs_pwr_w);
        LOOP_RSVD:  tgt_d = eff_w;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sb_q    <= 1'b1;
      sleep_q <= 1'b0;
      zcnt_q  <= 24'h00_0000;
      cmd_q   <= 10'h000;
      stop_q  <= 1'b1;
      tgt_q   <= 10'h000;
      spd_q   <= 16'h0000;
      pwr_q   <= 16'h0000;
      ramp_q  <= 10'h000;
    end else begin
      sb_q    <= sb_d;
      sleep_q <= sleep_d;
      zcnt_q  <= zcnt_d;
      cmd_q   <= cmd_d;
      stop_q  <= stop_d;
      tgt_q   <= tgt_d;
      spd_q   <= spd_d;
      pwr_q   <= pwr_d;
      ramp_q  <= ramp_d;
    end
  end

  mscp_pin_meas #(
    .GATE_CYC (FREQ_GATE_CYC)
  ) u_meas (
    .pclk      (pclk),
    .presetn   (presetn),
    .speed_pin (speed_pin),
    .mif       (mif)
  );

  mscp_ramp #(
    .W (10)
  ) u_ramp (
    .pclk    (pclk),
    .presetn (presetn),
    .target  (ramp_q),
    .accel   (acc_w),
    .decel   (dec_w),
    .applied (applied_w)
  );

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign duty_command        = cmd_q;
  assign target_output_duty  = tgt_q;
  assign speed_reference     = spd_q;
  assign power_reference     = pwr_q;
  assign applied_output_duty = applied_w;
  assign standby             = sb_q;
  assign sleep_mode          = sleep_q;
  assign motor_stopped       = stop_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ana_full;
    src_w == SRC_ANALOG && adc_code >= ana_fs_w && ana_fs_w > ana_ent_w
      |=> cmd_q == `MSCP_CMD_FULL;
  endproperty
  a_ana_full: assert property (p_ana_full)
    else $error("analog command not clamped at full scale");

  property p_ana_zero;
    src_w == SRC_ANALOG && adc_code <= ana_ent_w |=> cmd_q == 10'h000 && sb_q;
  endproperty
  a_ana_zero: assert property (p_ana_zero)
    else $error("analog command not zero below standby level");

  property p_pwm_zero;
    src_w == SRC_PWM && mif.duty <= pwm_ent_w |=> cmd_q == 10'h000;
  endproperty
  a_pwm_zero: assert property (p_pwm_zero)
    else $error("duty command not zero at standby duty");

  property p_pwm_full;
    src_w == SRC_PWM && mif.duty == `MSCP_CMD_FULL && pwm_ent_w != `MSCP_CMD_FULL
      |=> cmd_q == `MSCP_CMD_FULL;
  endproperty
  a_pwm_full: assert property (p_pwm_full)
    else $error("full input duty did not give full command");

  property p_host;
    src_w == SRC_HOST && host_w > host_sb_w && mif.pin_lvl |=> cmd_q == $past(host_w);
  endproperty
  a_host: assert property (p_host)
    else $error("host speed word not taken as command");

  property p_frq_zero;
    src_w == SRC_FREQ && mif.freq <= frq_ent_w |=> cmd_q == 10'h000;
  endproperty
  a_frq_zero: assert property (p_frq_zero)
    else $error("frequency command not zero at standby frequency");

  property p_stop;
    cmd_q < stop_w && $stable(stop_w)
      |=> motor_stopped && tgt_q == 10'h000 && spd_q == 16'h0000 && pwr_q == 16'h0000;
  endproperty
  a_stop: assert property (p_stop)
    else $error("reference not zero below stop threshold");

  property p_clamp;
    loop_w == LOOP_OPEN && cmd_q >= stop_w && cmd_q < min_w
      |=> tgt_q == $past(min_w);
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("open loop target not clamped to minimum");

  property p_spd_full;
    loop_w == LOOP_SPEED && cmd_q == `MSCP_CMD_FULL
      |=> spd_q == $past(fs_spd_w) && tgt_q == 10'h000;
  endproperty
  a_spd_full: assert property (p_spd_full)
    else $error("full command did not give full scale speed");

  property p_pwr_full;
    loop_w == LOOP_POWER && cmd_q == `MSCP_CMD_FULL
      |=> pwr_q == $past(fs_pwr_w);
  endproperty
  a_pwr_full: assert property (p_pwr_full)
    else $error("full command did not give full scale power");

  property p_rsvd;
    loop_w == LOOP_RSVD && cmd_q >= stop_w
      |=> tgt_q == $past((cmd_q < min_w) ? min_w : cmd_q) && spd_q == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved loop type did not act as open loop");

  sequence s_wake_cause;
    src_w == SRC_HOST && sleep_q && mif.pin_lvl;
  endsequence
  sequence s_awake;
    !sleep_q ##1 (src_w != SRC_HOST || mif.pin_lvl == 1'b0 || !sleep_q);
  endsequence
  property p_wake;
    s_wake_cause |=> s_awake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("sleep not left on high speed pin");

  property p_sleep;
    src_w == SRC_HOST && !mif.pin_lvl && host_w == 10'h000 && zcnt_q > dly_w |=> sleep_q;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep not entered after zero word delay");

  property p_stby;
    src_w == SRC_HOST && host_w <= host_sb_w && mif.pin_lvl
      |=> standby && cmd_q == 10'h000;
  endproperty
  a_stby: assert property (p_stby)
    else $error("standby not held for small host word");
endmodule : mscp_top
`default_nettype wire

/* test/mscp_host.sv */
// Host model: drives the speed pin as a square wave or a steady level
// Assumes the bench sets the high and low counts in pclk cycles
`timescale 1ns/1ns
`default_nettype none
module mscp_host (
  // Clock
  input  wire logic       pclk,
  // Wave shape, zero high count holds the pin low
  input  wire logic [7:0] hi_cyc,
  input  wire logic [7:0] lo_cyc,
  // Speed pin
  output var logic        speed_pin
);
  int cnt = 0;
  // Edges land right after pclk so the pin is never sampled mid-change
  always @(posedge pclk) begin
    cnt <= (cnt + 1 >= hi_cyc + lo_cyc) ? 0 : cnt + 1;
    speed_pin <= (cnt < hi_cyc);
  end
endmodule : mscp_host
`default_nettype wire

/* test/mscp_top_test.sv */
// Bench for the speed command path: APB master, pin host model, checks
// Assumes a short frequency gate of 200 cycles
`include "mscp_map.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(s, e) begin note_q.push_back({4'(s), 32'(e)}); -> look; #1; end
module mscp_top_test;
  import mscp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, speed_pin;
  logic [7:0] paddr = 0, hi_c = 0, lo_c = 0;
  logic [31:0] pwdata = 0, prdata, rd, se, seed = 32'haf88_3bd5;
  logic [11:0] adc_code = 0;
  logic [9:0] duty_command, target_output_duty, applied_output_duty;
  logic [15:0] speed_reference, power_reference;
  logic standby, sleep_mode, motor_stopped;
  logic [35:0] note_q[$];
  logic [11:0] av[4] = '{12'h080, 12'h140, 12'h1c0, 12'h000};
  logic [9:0] cv[4] = '{10'h000, 10'h026, 10'h04d, 10'h3ff};
  logic [9:0] tv[4] = '{10'h000, 10'h033, 10'h04d, 10'h3ff};
  string nm[10] = '{"cmd", "tgt", "spd", "pwr", "slp", "sby", "stp", "rd", "err", "app"};
  int err_total = 0, n_tests = 0, cyc = 0;
  event look;
  always #50 pclk = ~pclk;
  mscp_top #(.FREQ_GATE_CYC(200)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .speed_pin, .adc_code, .duty_command,
    .target_output_duty, .speed_reference, .power_reference, .applied_output_duty,
    .standby, .sleep_mode, .motor_stopped);
  mscp_host host (.pclk, .hi_cyc(hi_c), .lo_cyc(lo_c), .speed_pin);
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end
  always @(look) begin : watch
    logic [35:0] n;
    logic [31:0] v[10];
    v = '{32'(duty_command), 32'(target_output_duty), 32'(speed_reference),
          32'(power_reference), 32'(sleep_mode), 32'(standby), 32'(motor_stopped), rd, se,
          32'(applied_output_duty)};
    n = note_q.pop_front();
    n_tests++;
    if (v[n[35:32]] !== n[31:0]) begin
      err_total++;
      $display("unexpected %s exp %h got %h", nm[n[35:32]], n[31:0], v[n[35:32]]);
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = 32'(pslverr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [3:0] ix, input logic [31:0] d);
    apb(1'b1, {2'b00, ix, 2'b00}, d);
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  initial begin
    tick(4);
    presetn <= 1'b1;
    apb(1'b0, {2'b00, `MSCP_IX_STOPMIN, 2'b00}, 32'h0000_0000);
    `CHK(7, `MSCP_RST_STOPMIN)
    apb(1'b0, 8'hc0, 32'h0000_0000);
    `CHK(8, 1)
    wr(`MSCP_IX_RAMP, 32'h0000_0000);
    av[3] = 12'he00 | 12'(xs() & 32'h0000_01ff);
    for (int i = 0; i < 4; i++) begin
      adc_code <= av[i];
      tick(4);
      `CHK(0, cv[i])
      `CHK(1, tv[i])
      `CHK(6, i == 0)
    end
    tick(250);
    `CHK(9, 10'h3ff)
    wr(`MSCP_IX_CTRL, 32'h0000_0004);
    tick(4);
    `CHK(2, 16'h0bb8)
    wr(`MSCP_IX_CTRL, 32'h0000_0008);
    tick(4);
    `CHK(3, 16'h0064)
    wr(`MSCP_IX_CTRL, 32'h0000_000c);
    tick(4);
    `CHK(1, 10'h3ff)
    hi_c <= 8'd4;
    lo_c <= 8'd4;
    wr(`MSCP_IX_CTRL, 32'h0000_0003);
    tick(700);
    `CHK(0, 10'h015)
    hi_c <= 8'd15;
    lo_c <= 8'd16;
    for (int r = 0; r < 2; r++) begin
      wr(`MSCP_IX_CTRL, 32'(r * 16 + 1));
      tick(r ? 9000 : 2300);
      `CHK(0, 10'h1e4)
    end
    for (int p = 0; p < 2; p++) begin
      hi_c <= 8'(p);
      lo_c <= 8'(1 - p);
      wr(`MSCP_IX_CTRL, 32'h0000_0001);
      tick(2300);
      `CHK(0, p ? 10'h3ff : 10'h000)
    end
    wr(`MSCP_IX_SLEEP_DLY, 32'h0000_0014);
    wr(`MSCP_IX_HOST_SPD, 32'h0000_03ff);
    wr(`MSCP_IX_CTRL, 32'h0000_0002);
    tick(4);
    `CHK(0, 10'h3ff)
    hi_c <= 8'd1;
    lo_c <= 8'd0;
    wr(`MSCP_IX_HOST_SPD, 32'h0000_0000);
    tick(8);
    `CHK(5, 1)
    hi_c <= 8'd0;
    tick(40);
    `CHK(4, 1)
    hi_c <= 8'd1;
    tick(8);
    `CHK(4, 0)
    close_out();
  end
endmodule : mscp_top_test
`default_nettype wire
